// file: hw/rpaw_regs_consts.vh
// Purpose: constants for the pipe address and payload width register slice
// Assumes: byte-wide register port, offsets are register indices
// Notes:   multi-byte registers are written low byte first
`ifndef RPAW_REGS_CONSTS_VH
`define RPAW_REGS_CONSTS_VH
`define RPAW_OFF_P0_ADDR     8'h0A
`define RPAW_OFF_P1_ADDR     8'h0B
`define RPAW_OFF_P4_ADDR     8'h0E
`define RPAW_OFF_P5_ADDR     8'h0F
`define RPAW_OFF_TX_ADDR     8'h10
`define RPAW_OFF_P0_PW       8'h11
`define RPAW_OFF_P1_PW       8'h12
`define RPAW_OFF_P2_PW       8'h13
`define RPAW_OFF_P3_PW       8'h14
`define RPAW_OFF_P4_PW       8'h15
`define RPAW_RST_P0_ADDR     40'hE7_E7E7_E7E7
`define RPAW_RST_P1_ADDR     40'hC2_C2C2_C2C2
`define RPAW_RST_P4_ADDR     8'hC5
`define RPAW_RST_P5_ADDR     8'hC6
`define RPAW_RST_TX_ADDR     40'hE7_E7E7_E7E7
`define RPAW_RST_PW          6'h00
`define RPAW_PW_MSB          5
`define RPAW_PW_MAX          6'h20
`define RPAW_AW_MAX          3'h5
`endif

// file: hw/rpaw_byte_reg.v
// Purpose: one multi-byte register loaded low byte first
// Assumes: byteIdx counts bytes within the current access
// Notes:   bytes past the width are ignored
`timescale 1ns/100ps
module rpaw_byte_reg #(
  parameter [39:0] RESET_VAL = 40'h00_0000_0000
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // write side
  input  wire        wrEn,
  input  wire [2:0]  byteIdx,
  input  wire [2:0]  byteCount,
  input  wire [7:0]  wrData,
  // value
  output reg  [39:0] value_reg
);
  reg [39:0] value_next;
  integer    i;

  always @* begin
    value_next = value_reg;
    if (wrEn && byteIdx < byteCount) begin
      for (i = 0; i < 5; i = i + 1) begin
        if (byteIdx == i[2:0]) begin
          value_next[i*8 +: 8] = wrData;
        end
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      value_reg <= RESET_VAL;
    end else begin
      value_reg <= value_next;
    end
  end
endmodule

// file: hw/rpaw_regs.v
// Purpose: pipe address and receive payload width register slice
// Assumes: command port presents a register index and a byte index
// Notes:   bytes of one access arrive low byte first
// Operation
// - pipe 4 address keeps low byte, reset C5, upper bytes from pipe 1
// - pipe 5 address keeps low byte, reset C6, upper bytes from pipe 1
// - 40-bit read/write transmit address, used in transmitter role only
// - transmit address written low byte first into ascending positions
// - pipe 0 payload width, bits 5:0, reset zero, 0 unused
// - pipe 1 payload width, bits 5:0, reset zero, 0 unused
// - pipe 2 payload width, bits 5:0, reset zero, 0 unused
// - pipe 3 payload width, bits 5:0, reset zero, 0 unused
// - pipe 0 and 1 addresses written low byte first, width bytes
`timescale 1ns/100ps
`include "rpaw_regs_consts.vh"
module rpaw_regs (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // register command port
  input  wire        regWrite,
  input  wire        regRead,
  input  wire [7:0]  regIndex,
  input  wire [2:0]  byteIndex,
  input  wire [7:0]  writeData,
  output reg  [7:0]  readData_reg,
  output wire        regHit,
  // configuration in
  input  wire [2:0]  addressWidthSetting,
  input  wire        primaryTransmitterRole,
  // settings out
  output wire [39:0] pipe0RxAddress,
  output wire [39:0] pipe1RxAddress,
  output wire [39:0] pipe4RxAddress,
  output wire [39:0] pipe5RxAddress,
  output wire [39:0] transmitAddress,
  output wire [39:0] activeTxAddress,
  output wire [5:0]  pipe0RxPayloadWidth,
  output wire [5:0]  pipe1RxPayloadWidth,
  output wire [5:0]  pipe2RxPayloadWidth,
  output wire [5:0]  pipe3RxPayloadWidth,
  output wire [5:0]  pipe4RxPayloadWidth
);
  reg  [7:0]  pipe4Low_reg;
  reg  [7:0]  pipe5Low_reg;
  reg  [5:0]  pw_reg [0:4];
  reg  [7:0]  readData_next;
  wire [39:0] p0Addr;
  wire [39:0] p1Addr;
  wire [39:0] txAddr;
  wire [2:0]  byteCount;
  integer     k;

  function [7:0] rpaw_pick;
    input [39:0] v;
    input [2:0]  idx;
    begin
      case (idx)
        3'h0:    rpaw_pick = v[7:0];
        3'h1:    rpaw_pick = v[15:8];
        3'h2:    rpaw_pick = v[23:16];
        3'h3:    rpaw_pick = v[31:24];
        3'h4:    rpaw_pick = v[39:32];
        default: rpaw_pick = 8'h00;
      endcase
    end
  endfunction

  // clamp width to three..five bytes, outside that use five
  assign byteCount = (addressWidthSetting >= 3'h3 &&
                      addressWidthSetting <= `RPAW_AW_MAX) ?
                     addressWidthSetting : `RPAW_AW_MAX;

  rpaw_byte_reg #(.RESET_VAL(`RPAW_RST_P0_ADDR)) p0Inst (
    .clk       (clk),
    .rst_b     (rst_b),
    .wrEn      (regWrite && regIndex == `RPAW_OFF_P0_ADDR),
    .byteIdx   (byteIndex),
    .byteCount (byteCount),
    .wrData    (writeData),
    .value_reg (p0Addr)
  );

  rpaw_byte_reg #(.RESET_VAL(`RPAW_RST_P1_ADDR)) p1Inst (
    .clk       (clk),
    .rst_b     (rst_b),
    .wrEn      (regWrite && regIndex == `RPAW_OFF_P1_ADDR),
    .byteIdx   (byteIndex),
    .byteCount (byteCount),
    .wrData    (writeData),
    .value_reg (p1Addr)
  );

  // transmit address accepts all five bytes in ascending order
  rpaw_byte_reg #(.RESET_VAL(`RPAW_RST_TX_ADDR)) txInst (
    .clk       (clk),
    .rst_b     (rst_b),
    .wrEn      (regWrite && regIndex == `RPAW_OFF_TX_ADDR),
    .byteIdx   (byteIndex),
    .byteCount (`RPAW_AW_MAX),
    .wrData    (writeData),
    .value_reg (txAddr)
  );

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pipe4Low_reg <= `RPAW_RST_P4_ADDR;
      pipe5Low_reg <= `RPAW_RST_P5_ADDR;
      for (k = 0; k < 5; k = k + 1) begin
        pw_reg[k] <= `RPAW_RST_PW;
      end
    end else if (regWrite && byteIndex == 3'h0) begin
      if (regIndex == `RPAW_OFF_P4_ADDR) begin
        pipe4Low_reg <= writeData;
      end
      if (regIndex == `RPAW_OFF_P5_ADDR) begin
        pipe5Low_reg <= writeData;
      end
      for (k = 0; k < 5; k = k + 1) begin
        if (regIndex == `RPAW_OFF_P0_PW + k[7:0]) begin
          // upper two bits dropped, width held in bits 5:0
          pw_reg[k] <= writeData[`RPAW_PW_MSB:0];
        end
      end
    end
  end

  assign regHit = (regIndex == `RPAW_OFF_P0_ADDR) ||
                  (regIndex == `RPAW_OFF_P1_ADDR) ||
                  (regIndex >= `RPAW_OFF_P4_ADDR &&
                   regIndex <= `RPAW_OFF_P4_PW);

  always @* begin
    readData_next = readData_reg;
    if (regRead) begin
      case (regIndex)
        `RPAW_OFF_P0_ADDR: readData_next = rpaw_pick(p0Addr, byteIndex);
        `RPAW_OFF_P1_ADDR: readData_next = rpaw_pick(p1Addr, byteIndex);
        `RPAW_OFF_P4_ADDR: readData_next = pipe4Low_reg;
        `RPAW_OFF_P5_ADDR: readData_next = pipe5Low_reg;
        `RPAW_OFF_TX_ADDR: readData_next = rpaw_pick(txAddr, byteIndex);
        `RPAW_OFF_P0_PW:   readData_next = {2'b00, pw_reg[0]};
        `RPAW_OFF_P1_PW:   readData_next = {2'b00, pw_reg[1]};
        `RPAW_OFF_P2_PW:   readData_next = {2'b00, pw_reg[2]};
        `RPAW_OFF_P3_PW:   readData_next = {2'b00, pw_reg[3]};
        `RPAW_OFF_P4_PW:   readData_next = {2'b00, pw_reg[4]};
        default:           readData_next = 8'h00;
      endcase
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      readData_reg <= 8'h00;
    end else begin
      readData_reg <= readData_next;
    end
  end

  assign pipe0RxAddress      = p0Addr;
  assign pipe1RxAddress      = p1Addr;
  assign pipe4RxAddress      = {p1Addr[39:8], pipe4Low_reg};
  assign pipe5RxAddress      = {p1Addr[39:8], pipe5Low_reg};
  assign transmitAddress     = txAddr;
  // transmit address only drives the radio in the transmitter role
  assign activeTxAddress     = primaryTransmitterRole ? txAddr :
                               40'h00_0000_0000;
  assign pipe0RxPayloadWidth = pw_reg[0];
  assign pipe1RxPayloadWidth = pw_reg[1];
  assign pipe2RxPayloadWidth = pw_reg[2];
  assign pipe3RxPayloadWidth = pw_reg[3];
  assign pipe4RxPayloadWidth = pw_reg[4];
endmodule

// file: sim/rpaw_regs_chk.sv
// Purpose: assertions on the pipe address and width register slice
// Assumes: one byte per strobe cycle
// Notes:   bound to every rpaw_regs instance
`timescale 1ns/100ps
module rpaw_regs_chk (
  input logic        clk, rst_b, regWrite, regRead, primaryTransmitterRole,
  input logic [7:0]  regIndex, writeData, readData_reg,
  input logic [2:0]  byteIndex,
  input logic [5:0]  pipe0RxPayloadWidth,
  input logic [39:0] pipe1RxAddress, pipe4RxAddress, pipe5RxAddress,
  input logic [39:0] transmitAddress, activeTxAddress
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire lowWr = regWrite && byteIndex == 3'h0;
  property p_p4up; pipe4RxAddress[39:8] == pipe1RxAddress[39:8]; endproperty
  a_p4up: assert property (p_p4up) else $error("pipe4 upper bytes");
  property p_p5up; pipe5RxAddress[39:8] == pipe1RxAddress[39:8]; endproperty
  a_p5up: assert property (p_p5up) else $error("pipe5 upper bytes");
  property p_rst; $rose(rst_b) |-> pipe4RxAddress[7:0] == 8'hc5 &&
    pipe5RxAddress[7:0] == 8'hc6; endproperty
  a_rst: assert property (p_rst) else $error("low byte reset");
  property p_p4wr; lowWr && regIndex == 8'h0e |=>
    pipe4RxAddress[7:0] == $past(writeData); endproperty
  a_p4wr: assert property (p_p4wr) else $error("pipe4 write");
  property p_p5wr; lowWr && regIndex == 8'h0f |=>
    pipe5RxAddress[7:0] == $past(writeData); endproperty
  a_p5wr: assert property (p_p5wr) else $error("pipe5 write");
  property p_tx; regWrite && regIndex == 8'h10 && byteIndex < 3'h5 |=>
    8'(transmitAddress >> {$past(byteIndex), 3'h0}) == $past(writeData);
  endproperty
  a_tx: assert property (p_tx) else $error("tx byte position");
  property p_act; activeTxAddress ==
    (primaryTransmitterRole ? transmitAddress : 40'h0); endproperty
  a_act: assert property (p_act) else $error("active tx address");
  property p_pw; lowWr && regIndex == 8'h11 |=>
    pipe0RxPayloadWidth == $past(writeData[5:0]); endproperty
  a_pw: assert property (p_pw) else $error("pipe0 width");
  property p_rd; regRead && regIndex inside {[8'h11:8'h15]} |=>
    readData_reg[7:6] == 2'h0; endproperty
  a_rd: assert property (p_rd) else $error("width reserved bits");
  c_tx: cover property (regWrite && regIndex == 8'h10 && byteIndex == 3'h4);
  c_rd: cover property (regRead && regIndex == 8'h14);
  c_act: cover property (primaryTransmitterRole && regWrite);
endmodule
bind rpaw_regs rpaw_regs_chk chk_u (.*);

// file: sim/rpaw_regs_tb.sv
// Purpose: random and corner tests of the register slice
// Assumes: byte index driven by the bench
// Notes:   second reset issued mid-run
`timescale 1ns/100ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_errors++; \
  $display("wrong value at %0t: %h %h", $time, a, b); end end
module rpaw_regs_tb;
  logic clk = 0, rst_b = 0, regWrite = 0, regRead = 0;
  logic primaryTransmitterRole = 0;
  logic [7:0] regIndex = 0, writeData = 0, d;
  logic [2:0] byteIndex = 0, addressWidthSetting = 3'h5;
  wire [7:0] readData_reg;
  wire regHit;
  wire [39:0] pipe0RxAddress, pipe1RxAddress, pipe4RxAddress;
  wire [39:0] pipe5RxAddress, transmitAddress, activeTxAddress;
  wire [5:0] pipe0RxPayloadWidth, pipe1RxPayloadWidth;
  wire [5:0] pipe2RxPayloadWidth, pipe3RxPayloadWidth, pipe4RxPayloadWidth;
  wire [29:0] allW = {pipe4RxPayloadWidth, pipe3RxPayloadWidth,
    pipe2RxPayloadWidth, pipe1RxPayloadWidth, pipe0RxPayloadWidth};
  integer n_errors = 0, checks = 0, seed = 28, i, k;
  logic [39:0] v;
  always #4 clk = ~clk;
  rpaw_regs dut_u (.*);
  function automatic [39:0] expAct(input r, input [39:0] t);
    expAct = r ? t : 40'h0;
  endfunction
  task automatic acc(input w, input [7:0] x, input [2:0] b, input [7:0] y);
    @(posedge clk);
    #1;
    {regWrite, regRead, regIndex, byteIndex, writeData} = {w, !w, x, b, y};
    @(posedge clk);
    #1;
    {regWrite, regRead} = 2'h0;
  endtask
  task automatic wr40(input [7:0] x, input [39:0] y);
    for (k = 0; k < 5; k++) acc(1, x, k[2:0], y[8*k+:8]);
  endtask
  task complete_run;
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    #100000;
    n_errors++;
    complete_run;
  end
  initial begin
    repeat (6) @(posedge clk);
    #1 rst_b = 1;
    `CHK(pipe0RxAddress, 40'he7_e7e7_e7e7)
    `CHK(pipe4RxAddress, 40'hc2_c2c2_c2c5)
    `CHK(pipe5RxAddress, 40'hc2_c2c2_c2c6)
    `CHK(allW, 30'h0)
    for (i = 0; i < 12; i++) begin
      v = {8'($random(seed)), 32'($random(seed))};
      d = (i == 0) ? 8'h20 : (i == 1) ? 8'h00 : 8'($random(seed));
      primaryTransmitterRole = d[0];
      wr40(8'h10, v);
      `CHK(transmitAddress, v)
      `CHK(activeTxAddress, expAct(d[0], v))
      wr40(8'h0a, v);
      `CHK(pipe0RxAddress, v)
      wr40(8'h0b, ~v);
      acc(1, 8'h0e, 0, d);
      `CHK(pipe4RxAddress, {~v[39:8], d})
      `CHK(pipe5RxAddress[39:8], ~v[39:8])
      acc(1, 8'(17 + i % 5), 0, {2'h0, d[5:0]});
      `CHK(allW[6*(i%5)+:6], d[5:0])
      acc(0, 8'(17 + i % 5), 0, 8'h00);
      `CHK(readData_reg, {2'h0, d[5:0]})
      acc(0, 8'h10, 3'(i % 5), 8'h00);
      `CHK(readData_reg, v[8*(i%5)+:8])
      `CHK(regHit, 1'b1)
    end
    acc(0, 8'h30, 0, 8'h00);
    `CHK(readData_reg, 8'h00)
    `CHK(regHit, 1'b0)
    // three-byte width: bytes 3 and 4 of the pipe 1 write are ignored
    addressWidthSetting = 3'h3;
    wr40(8'h0b, v);
    `CHK(pipe1RxAddress, {~v[39:24], v[23:0]})
    rst_b = 0;
    #20;
    `CHK(transmitAddress, 40'he7_e7e7_e7e7)
    rst_b = 1;
    @(posedge clk);
    #1;
    `CHK(pipe1RxAddress, 40'hc2_c2c2_c2c2)
    `CHK(pipe4RxAddress[7:0], 8'hc5)
    acc(1, 8'h0f, 0, 8'h5a);
    `CHK(pipe5RxAddress, 40'hc2_c2c2_c25a)
    complete_run;
  end
endmodule
